// File: common/dl_status_pkg.sv
// Purpose: Constants for the data link status register bank
// Assumes: APB slave, 32-bit data, one aligned word per register
// Notes:   Offsets of the bank are local choices
package dl_status_pkg;

	localparam int          ADDR_W          = 12;
	localparam logic [11:0] STATUS_OFFSET   = 12'h000;
	localparam logic [11:0] MSG_KIND_OFFSET = 12'h004;

	localparam int MSG_KIND_POS  = 7;
	localparam int TX_START_POS  = 6;
	localparam int RX_START_POS  = 5;
	localparam int TX_END_POS    = 4;
	localparam int RX_END_POS    = 3;
	localparam int FCS_ERR_POS   = 2;
	localparam int NUM_EVENTS    = 5;
	localparam int EVENT_LSB     = 2;

	localparam logic [4:0] EVENTS_RESET   = 5'h00;
	localparam logic       MSG_KIND_RESET = 1'b0;

endpackage

// File: core/sticky_event_bits.sv
// Purpose: Sticky event flags cleared by a host read
// Assumes: Events and clear come from logic on the same clock
// Notes:   A set in the clearing cycle survives the clear
module sticky_event_bits #(
	parameter int N = 5
) (
	input  wire logic         clk,
	input  wire logic         rstn,
	input  wire logic [N-1:0] set_i,
	input  wire logic         clear_i,
	output logic      [N-1:0] flags_q
);

	initial begin
		if (N < 1)
			$error("sticky_event_bits needs N >= 1");
	end

	typedef struct packed {
		logic [N-1:0] flags;
	} state_t;

	state_t s_q;
	state_t s_d;

	always_comb begin
		s_d = s_q;
		for (int i = 0; i < N; i++) begin
			if (set_i[i])
				s_d.flags[i] = 1'b1; // [RULE_09]
			else if (clear_i)
				s_d.flags[i] = 1'b0; // [RULE_07]
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign flags_q = s_q.flags;

endmodule // sticky_event_bits

// File: core/hdlc_link_status_flags.sv
// Purpose: Data link status register one for the first HDLC pair
// Assumes: Event strobes are single-cycle pulses on clk
// Notes:   Reading the status word clears its event flags
//          Access answers with no wait state
//          Writes and unmapped reads end with pslverr
//          An event in the clearing cycle survives it
//          Kind bit follows the latest received message
//          Abort and idle flags are not kept here
//
// Behaviour
// [RULE_01] Bit 7 shows last received message kind
// [RULE_02] Bit 6 set when transmit message starts
// [RULE_03] Bit 5 set when receive message starts
// [RULE_04] Bit 4 set when transmit message ends
// [RULE_05] Bit 3 set on receive end or full
// [RULE_06] Bit 2 set on frame check mismatch
// [RULE_07] Flags show events since read; read clears
// [RULE_08] Host loads next buffer between start, end
// [RULE_09] Event during clearing read stays set; here only in the access cycle, an event in the setup cycle is cleared unread
module hdlc_link_status_flags
	import dl_status_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rstn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              tx_msg_start,
	input  wire logic              rx_msg_start,
	input  wire logic              tx_msg_end,
	input  wire logic              rx_msg_end,
	input  wire logic              rx_buffer_full,
	input  wire logic              rx_fcs_mismatch,
	input  wire logic              rx_msg_done,
	input  wire logic              rx_msg_is_mos
);

	// Package layout must fit one status byte
	initial begin
		if (ADDR_W < 3)
			$error("address must reach the mirror word");
		if (ADDR_W > 32)
			$error("address wider than the bus");
		if (MSG_KIND_POS > 7)
			$error("message kind bit must sit in the low byte");
		if (EVENT_LSB + NUM_EVENTS > MSG_KIND_POS)
			$error("event flags overlap the message kind bit");
		if (TX_START_POS != EVENT_LSB + 4)
			$error("transmit start flag out of place");
		if (RX_START_POS != EVENT_LSB + 3)
			$error("receive start flag out of place");
		if (TX_END_POS != EVENT_LSB + 2)
			$error("transmit end flag out of place");
		if (RX_END_POS != EVENT_LSB + 1)
			$error("receive end flag out of place");
		if (FCS_ERR_POS != EVENT_LSB)
			$error("check error flag out of place");
		if (STATUS_OFFSET[1:0] != 2'b00 || MSG_KIND_OFFSET[1:0] != 2'b00)
			$error("register offsets must be word aligned");
		if (STATUS_OFFSET == MSG_KIND_OFFSET)
			$error("status and mirror offsets must differ");
	end

	// Kind of access seen in the setup cycle
	typedef enum {
		ACC_IDLE,
		ACC_STATUS,
		ACC_KIND,
		ACC_WRITE,
		ACC_UNMAPPED
	} access_t;

	typedef struct packed {
		logic        msg_kind;
		logic [31:0] rdata;
		logic        ready;
		logic        slverr;
	} state_t;

	state_t s_q;
	state_t s_d;

	logic [NUM_EVENTS-1:0] ev_set;
	logic [NUM_EVENTS-1:0] ev_flags;
	logic                  setup;
	logic                  access;
	logic                  hit_status;
	logic                  hit_kind;
	logic                  read_clear;
	logic [7:0]            status_byte;
	access_t               acc_kind;

	assign setup      = psel && !penable;
	assign access     = psel && penable;
	assign hit_status = (paddr == STATUS_OFFSET);
	assign hit_kind   = (paddr == MSG_KIND_OFFSET);

	// Writes are refused before the address is looked at
	always_comb begin
		if (!setup)
			acc_kind = ACC_IDLE;
		else if (pwrite)
			acc_kind = ACC_WRITE;
		else if (hit_status)
			acc_kind = ACC_STATUS;
		else if (hit_kind)
			acc_kind = ACC_KIND;
		else
			acc_kind = ACC_UNMAPPED;
	end

	// Clear on the completing edge of a status read
	assign read_clear = access && s_q.ready && !pwrite
		&& hit_status; // [RULE_07]

	// One set line per flag, placed by its status bit
	for (genvar i = 0; i < NUM_EVENTS; i++) begin : g_ev_set
		localparam int POS = i + EVENT_LSB;
		if (POS == TX_START_POS) begin : g_tx_start
			assign ev_set[i] = tx_msg_start; // [RULE_02]
		end else if (POS == RX_START_POS) begin : g_rx_start
			assign ev_set[i] = rx_msg_start; // [RULE_03]
		end else if (POS == TX_END_POS) begin : g_tx_end
			assign ev_set[i] = tx_msg_end; // [RULE_04]
		end else if (POS == RX_END_POS) begin : g_rx_end
			// Full buffer ends reception as a message would
			assign ev_set[i] = rx_msg_end || rx_buffer_full; // [RULE_05]
		end else if (POS == FCS_ERR_POS) begin : g_fcs_err
			assign ev_set[i] = rx_fcs_mismatch; // [RULE_06]
		end else begin : g_spare
			assign ev_set[i] = 1'b0;
		end
	end

	// Flags live in a sticky bank; a set in the
	// clearing edge wins; an event in the read's setup cycle is cleared unread
	sticky_event_bits #(
		.N       (NUM_EVENTS)
	) u_flags (
		.clk     (clk),
		.rstn    (rstn),
		.set_i   (ev_set),
		.clear_i (read_clear),
		.flags_q (ev_flags)
	);

	// Status word: kind on top, event flags, two spare bits
	always_comb begin
		status_byte                          = 8'h00;
		status_byte[MSG_KIND_POS]            = s_q.msg_kind;
		status_byte[EVENT_LSB +: NUM_EVENTS] = ev_flags;
	end

	// Read data is taken at the setup edge and stands until
	// the next setup; pready and pslverr stand one cycle only
	always_comb begin
		s_d        = s_q;
		s_d.ready  = 1'b0;
		s_d.slverr = 1'b0;

		// Latest received message decides the kind bit
		if (rx_msg_done)
			s_d.msg_kind = rx_msg_is_mos; // [RULE_01]

		// No wait state: answer in the cycle after setup
		case (acc_kind)
			ACC_IDLE: begin
				s_d.ready = 1'b0;
			end
			ACC_STATUS: begin
				s_d.ready = 1'b1;
				s_d.rdata = {24'h00_0000, status_byte}; // [RULE_07]
			end
			ACC_KIND: begin
				s_d.ready = 1'b1;
				s_d.rdata = {31'h0000_0000, s_q.msg_kind}; // [RULE_01]
			end
			ACC_WRITE: begin
				// The bank is read-only
				s_d.ready  = 1'b1;
				s_d.rdata  = 32'h0000_0000;
				s_d.slverr = 1'b1;
			end
			ACC_UNMAPPED: begin
				// Nothing lives here
				s_d.ready  = 1'b1;
				s_d.rdata  = 32'h0000_0000;
				s_d.slverr = 1'b1;
			end
			default: begin
				s_d.ready = 1'b0;
			end
		endcase
	end

	// Synchronous reset to the defaults
	always_ff @(posedge clk) begin
		if (!rstn) begin
			s_q.msg_kind <= MSG_KIND_RESET;
			s_q.rdata    <= 32'h0000_0000;
			s_q.ready    <= 1'b0;
			s_q.slverr   <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs come straight from the state flops
	assign prdata  = s_q.rdata;
	assign pready  = s_q.ready;
	assign pslverr = s_q.slverr;

	// Write data is unused; the bank is read-only
	logic unused_wdata;
	assign unused_wdata = ^pwdata;

endmodule // hdlc_link_status_flags

// File: dv/ev_model.sv
// Purpose: event source. Assumes: one clock. Notes: pulses
module ev_model (
	input wire logic       clk, go,
	input wire logic [7:0] pat,
	output logic     [7:0] ev
);
	timeunit 1ns;
	timeprecision 1ps;
	always_ff @(posedge clk) ev <= go ? pat : 8'h00;
endmodule // ev_model

// File: dv/flags_monitor.sv
// Purpose: flag checks. Assumes: bind. Notes: setup-edge reads
module flags_monitor
	import dl_status_pkg::*;
(
	input wire logic clk, rstn, psel, penable, pwrite, pready, rx_msg_done,
	input wire logic tx_msg_start, rx_msg_start, tx_msg_end, rx_msg_end,
	input wire logic rx_buffer_full, rx_fcs_mismatch, rx_msg_is_mos,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] prdata
);
	wire rd = psel && !penable && !pwrite && paddr == STATUS_OFFSET;
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	msg_kind_a: assert property ($past(rx_msg_done) && rd |=>
		prdata[7] == $past(rx_msg_is_mos, 2)) else $error("kind");
	tx_start_a: assert property ($past(tx_msg_start) && rd |=>
		prdata[6]) else $error("txs");
	rx_start_a: assert property ($past(rx_msg_start) && rd |=>
		prdata[5]) else $error("rxs");
	tx_end_a: assert property ($past(tx_msg_end) && rd |=>
		prdata[4]) else $error("txe");
	rx_end_a: assert property ($past(rx_msg_end | rx_buffer_full) && rd
		|=> prdata[3]) else $error("rxe");
	fcs_err_a: assert property ($past(rx_fcs_mismatch) && rd |=>
		prdata[2]) else $error("fcs");
	read_clear_a: assert property (rd ##1 !rx_msg_start ##1 rd |=>
		!prdata[5]) else $error("clear");
	set_wins_a: assert property (pready && $past(rd) && tx_msg_end
		##1 rd |=> prdata[4]) else $error("keep");
endmodule // flags_monitor
bind hdlc_link_status_flags flags_monitor SM (.*);

// File: dv/hdlc_link_status_flags_tb.sv
// Purpose: bench. Assumes: APB host. Notes: queued checks
`define CHK(a, b) checks_done++; \
	if ((a) !== (b)) begin n_errors++; \
	$display("unexpected %0t read mismatch", $time); end
module hdlc_link_status_flags_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import dl_status_pkg::*;
	logic clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, go = 0, k;
	logic pready, pslverr;
	logic [11:0] paddr = 0;
	logic [31:0] prdata, pwdata = 0;
	logic [7:0] pat = 0, ev;
	logic [32:0] q[$];
	int n_errors = 0, checks_done = 0, cyc = 0;
	initial forever #2.5 clk = ~clk;
	ev_model EVM (.clk(clk), .go(go), .pat(pat), .ev(ev));
	hdlc_link_status_flags DUT (.clk(clk), .rstn(rstn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.tx_msg_start(ev[0]), .rx_msg_start(ev[1]), .tx_msg_end(ev[2]),
		.rx_msg_end(ev[3]), .rx_buffer_full(ev[4]),
		.rx_fcs_mismatch(ev[5]), .rx_msg_done(ev[6]), .rx_msg_is_mos(ev[7]));
	// Events land on the edge that completes this access
	task automatic x(logic [8:0] e, logic [7:0] p = 0,
		logic [11:0] a = STATUS_OFFSET, logic w = 0);
		q.push_back({e[8], 24'h0, e[7:0]});
		{psel, penable, pwrite, paddr, go, pat} <= {2'b10, w, a, 1'b1, p};
		@(posedge clk);
		{penable, go} <= 2'b10;
		do @(negedge clk); while (pready !== 1'b1);
		@(posedge clk);
	endtask
	task automatic stop_test();
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	always @(negedge clk) begin
		if (++cyc == 999) begin
			n_errors++;
			$display("unexpected %0t timeout", $time);
			stop_test();
		end else if (pready === 1'b1) begin
			`CHK({pslverr, prdata}, q.pop_front())
		end
	end
	initial begin
		void'($urandom(43));
		k = 1'($urandom);
		repeat (10) @(posedge clk);
		rstn <= 1;
		x(0, {k, 7'h40});
		for (int i = 0; i < 6; i++) begin
			x({k, 7'h0}, 8'h1 << i);
			x({k, 7'h40 >> i - (i > 3)});
		end
		x(k, 0, MSG_KIND_OFFSET);
		x(9'h100, 0, 12'h008);
		x({k, 7'h0});
		x({k, 7'h0}, 8'h3f);
		x(9'h100, 0, STATUS_OFFSET, 1'b1);
		x({k, 7'h7c}, 8'h3f);
		{psel, penable, rstn} <= 3'b000;
		repeat (2) @(posedge clk);
		rstn <= 1;
		x(0);
		{psel, penable} <= 2'b00;
		repeat (2) @(posedge clk);
		stop_test();
	end
endmodule // hdlc_link_status_flags_tb
